//--- common/hcp_map.svh
//------------------------------------------------------------------
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 20 MHz clock, byte offsets on the register port
// Notes:   included by the pin flag and register design files and the bench
//------------------------------------------------------------------
// Functional notes
// - bit 5 accepts general call, resets 0
// - bit 3 selects fast-mode-plus, resets 1
// - config done set after reset, held until next reset
// - bit 1 copies staged pin configuration
// - batch update refused while override pending
// - writing bit 0 starts chip reset
// - address bits 6:0 used, bit 7 zero
// - address from strap or otp at end of configuration
// - level status shows present pin levels
// - pin change sets its flag, reset zero
// - writing one clears that flag only
// - cleared flag re-arms for next change
// - flag and enable raise pin interrupt
// - enable mask per pin, resets zero
// - top status bit 1 shows pin interrupt
// - top status bit 12 mirrors config done
`ifndef HCP_MAP_SVH
`define HCP_MAP_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define HCP_OFS_TOP_STS 8'h10
`define HCP_OFS_HARDWARE_CONTROL 8'h18
`define HCP_OFS_ADDR 8'h1a
`define HCP_OFS_PIN_LVL 8'h20
`define HCP_OFS_PIN_CHG 8'h22
`define HCP_OFS_PIN_MASK 8'h24
`define HCP_OFS_EVT_STS 8'h28
`define HCP_OFS_EVT_MASK 8'h2a

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define HCP_BIT_GCALL 5
`define HCP_BIT_FMP 3
`define HCP_BIT_CFGD 2
`define HCP_BIT_UPD 1
`define HCP_BIT_SRST 0
`define HCP_BIT_TOP_PIN 1
`define HCP_BIT_TOP_RDY 12
`define HCP_EVT_PIN 0
`define HCP_EVT_RDY 1
`define HCP_EVT_UPD_DONE 2
`define HCP_EVT_UPD_REF 3
`define HCP_EVT_W 4

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define HCP_GCALL_RST 1'h0
`define HCP_FMP_RST 1'h1
`define HCP_PIN_CHG_RST 16'h0000
`define HCP_PIN_MASK_RST 16'h0000
`define HCP_EVT_MASK_RST 4'h0

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define HCP_CLK_NS 50
`define HCP_SRST_NS 1000
`define HCP_SRST_CYC ((`HCP_SRST_NS + `HCP_CLK_NS - 1) / `HCP_CLK_NS)
`define HCP_CFG_NS 2000
`define HCP_CFG_CYC ((`HCP_CFG_NS + `HCP_CLK_NS - 1) / `HCP_CLK_NS)

`endif

//--- common/hcp_pkg.sv
//------------------------------------------------------------------
// Purpose: state types of the control block
// Assumes: nothing
// Notes:   constants live in hcp_map.svh
//------------------------------------------------------------------
package hcp_pkg;

    typedef enum logic [1:0] {
        SEQ_RESET = 2'b00,
        SEQ_CONFIG = 2'b01,
        SEQ_READY = 2'b10
    } hcp_seq_t;

    typedef enum logic {
        UPD_IDLE = 1'b0,
        UPD_COPY = 1'b1
    } hcp_upd_t;

endpackage : hcp_pkg

//--- verilog/hcp_sync.sv
//------------------------------------------------------------------
// Purpose: two-stage synchroniser for a bus of unrelated levels
// Assumes: each bit is an independent level
// Notes:   stage one feeds stage two only
//------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module hcp_sync #(
    parameter int W = 16
) (
    // clock
    input wire logic mclk_in,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_reg;

    // no reset: levels are already true when reset ends, so no false edge
    always_ff @(posedge mclk_in) begin
        meta_reg <= d_in;
        q_out <= meta_reg;
    end

endmodule : hcp_sync
`default_nettype wire

//--- verilog/hcp_pin_flags.sv
//------------------------------------------------------------------
// Purpose: per-pin change detection with sticky write-one-clear flags
// Assumes: pin levels already synchronised
// Notes:   a change in the clearing cycle keeps its flag set
//------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "hcp_map.svh"
module hcp_pin_flags #(
    parameter int N = 16
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // pins and clear
    input wire logic [N-1:0] lvl_in,
    input wire logic [N-1:0] clr_in,
    // flags
    output logic [N-1:0] flags_out
);

    logic armed_reg;
    logic [N-1:0] prev_reg;

    // first cycle after reset only takes the baseline, so a pin
    // that is already high does not raise a false change
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            armed_reg <= 1'h0;
            prev_reg <= '0;
        end else begin
            armed_reg <= 1'h1;
            prev_reg <= lvl_in;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            always_ff @(posedge mclk_in) begin
                if (!rst_n_in) begin
                    flags_out[i] <= 1'(`HCP_PIN_CHG_RST >> i);
                end else if (armed_reg && (lvl_in[i] != prev_reg[i])) begin
                    flags_out[i] <= 1'h1;
                end else if (clr_in[i]) begin
                    flags_out[i] <= 1'h0;
                end
            end
        end
    endgenerate

endmodule : hcp_pin_flags
`default_nettype wire

//--- verilog/hcp_regs.sv
//------------------------------------------------------------------
// Purpose: hardware control, bus target address and pin change
//          registers with their interrupt logic
// Assumes: register port on mclk_in, read data one cycle later;
//          pins and strap come from outside the clock domain
// Notes:   soft chip reset re-runs the configuration sequence
//------------------------------------------------------------------
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "hcp_map.svh"
module hcp_regs
    import hcp_pkg::*;
#(
    parameter int NPIN = 16,
    parameter int NOVR = 4
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // pins and strap
    input wire logic [NPIN-1:0] pin_level_in,
    input wire logic [6:0] strap_addr_in,
    // one-time-programmable settings
    input wire logic otp_address_override_enable_in,
    input wire logic [6:0] otp_address_value_in,
    // pin configuration block
    input wire logic [NOVR-1:0] override_enable_bits_in,
    input wire logic pin_batch_copy_done_in,
    output logic pin_batch_update_request_out,
    // bus target controls
    output logic [6:0] bus_target_address_out,
    output logic general_call_accept_out,
    output logic fast_mode_plus_select_out,
    // chip control
    output logic soft_chip_reset_out,
    output logic config_done_flag_out,
    // interrupts
    output logic pin_change_interrupt_out,
    output logic irq_out
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam logic [7:0] SRST_LAST = 8'(`HCP_SRST_CYC - 1);
    localparam logic [7:0] CFG_LAST = 8'(`HCP_CFG_CYC - 1);

    hcp_seq_t seq_reg;
    hcp_upd_t upd_reg;
    logic [7:0] cnt_reg;
    logic blk_rst_n;
    logic [NPIN-1:0] pin_sync;
    logic [6:0] strap_sync;
    logic [NPIN-1:0] pin_change_flags;
    logic [NPIN-1:0] flag_clr;
    logic [NPIN-1:0] pin_change_irq_mask_reg;
    logic [`HCP_EVT_W-1:0] evt_reg;
    logic [`HCP_EVT_W-1:0] evt_next;
    logic [`HCP_EVT_W-1:0] evt_set;
    logic [`HCP_EVT_W-1:0] evt_mask_reg;
    logic wr_hardware_control;
    logic srst_req;
    logic upd_req;
    logic cfg_finish;
    logic pin_irq_next;
    logic [15:0] rdata_next;

    // registers return to defaults while the chip reset runs
    assign blk_rst_n = rst_n_in && !soft_chip_reset_out;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    hcp_sync #(
        .W(NPIN)
    ) u_pin_sync (
        .mclk_in(mclk_in),
        .d_in(pin_level_in),
        .q_out(pin_sync)
    );

    hcp_sync #(
        .W(7)
    ) u_strap_sync (
        .mclk_in(mclk_in),
        .d_in(strap_addr_in),
        .q_out(strap_sync)
    );

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign wr_hardware_control = reg_wr_in && (reg_addr_in == `HCP_OFS_HARDWARE_CONTROL);
    assign srst_req = wr_hardware_control && reg_wdata_in[`HCP_BIT_SRST]
        && (seq_reg != SEQ_RESET);
    assign upd_req = wr_hardware_control && reg_wdata_in[`HCP_BIT_UPD]
        && (upd_reg == UPD_IDLE) && !srst_req;
    assign cfg_finish = (seq_reg == SEQ_CONFIG) && (cnt_reg == CFG_LAST);

    always_comb begin
        flag_clr = '0;
        if (reg_wr_in && (reg_addr_in == `HCP_OFS_PIN_CHG)) begin
            flag_clr = reg_wdata_in[NPIN-1:0];
        end
    end

    // ------------------------------------------------------------------
    // reset and configuration sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            seq_reg <= SEQ_CONFIG;
            cnt_reg <= 8'h00;
        end else if (srst_req) begin
            seq_reg <= SEQ_RESET;
            cnt_reg <= 8'h00;
        end else begin
            case (seq_reg)
                SEQ_RESET: begin
                    if (cnt_reg == SRST_LAST) begin
                        seq_reg <= SEQ_CONFIG;
                        cnt_reg <= 8'h00;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                SEQ_CONFIG: begin
                    if (cfg_finish) begin
                        seq_reg <= SEQ_READY;
                        cnt_reg <= 8'h00;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                SEQ_READY: begin
                    cnt_reg <= 8'h00;
                end
                default: begin
                    seq_reg <= SEQ_CONFIG;
                    cnt_reg <= 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            soft_chip_reset_out <= 1'h0;
        end else if (srst_req) begin
            soft_chip_reset_out <= 1'h1;
        end else if ((seq_reg == SEQ_RESET) && (cnt_reg == SRST_LAST)) begin
            soft_chip_reset_out <= 1'h0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            config_done_flag_out <= 1'h0;
        end else if (cfg_finish) begin
            config_done_flag_out <= 1'h1;
        end
    end

    // ------------------------------------------------------------------
    // hardware control fields
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            general_call_accept_out <= `HCP_GCALL_RST;
            fast_mode_plus_select_out <= `HCP_FMP_RST;
        end else if (wr_hardware_control) begin
            general_call_accept_out <= reg_wdata_in[`HCP_BIT_GCALL];
            fast_mode_plus_select_out <= reg_wdata_in[`HCP_BIT_FMP];
        end
    end

    // ------------------------------------------------------------------
    // batch pin update
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            upd_reg <= UPD_IDLE;
            pin_batch_update_request_out <= 1'h0;
        end else begin
            case (upd_reg)
                UPD_IDLE: begin
                    if (upd_req && !(|override_enable_bits_in)) begin
                        upd_reg <= UPD_COPY;
                        pin_batch_update_request_out <= 1'h1;
                    end
                end
                UPD_COPY: begin
                    if (pin_batch_copy_done_in) begin
                        upd_reg <= UPD_IDLE;
                        pin_batch_update_request_out <= 1'h0;
                    end
                end
                default: begin
                    upd_reg <= UPD_IDLE;
                    pin_batch_update_request_out <= 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // bus target address
    // ------------------------------------------------------------------
    // strap is sampled at the end of configuration, well after release,
    // so it has long passed the synchroniser
    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            bus_target_address_out <= 7'h00;
        end else if (cfg_finish) begin
            if (otp_address_override_enable_in) begin
                bus_target_address_out <= otp_address_value_in;
            end else begin
                bus_target_address_out <= strap_sync;
            end
        end else if (reg_wr_in && (reg_addr_in == `HCP_OFS_ADDR)) begin
            bus_target_address_out <= reg_wdata_in[6:0];
        end
    end

    // ------------------------------------------------------------------
    // pin change flags and mask
    // ------------------------------------------------------------------
    hcp_pin_flags #(
        .N(NPIN)
    ) u_flags (
        .mclk_in(mclk_in),
        .rst_n_in(blk_rst_n),
        .lvl_in(pin_sync),
        .clr_in(flag_clr),
        .flags_out(pin_change_flags)
    );

    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            pin_change_irq_mask_reg <= NPIN'(`HCP_PIN_MASK_RST);
        end else if (reg_wr_in && (reg_addr_in == `HCP_OFS_PIN_MASK)) begin
            pin_change_irq_mask_reg <= reg_wdata_in[NPIN-1:0];
        end
    end

    assign pin_irq_next = |(pin_change_flags & pin_change_irq_mask_reg);

    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            pin_change_interrupt_out <= 1'h0;
        end else begin
            pin_change_interrupt_out <= pin_irq_next;
        end
    end

    // ------------------------------------------------------------------
    // block events: sticky, cleared by reading, set wins
    // ------------------------------------------------------------------
    always_comb begin
        evt_set = '0;
        evt_set[`HCP_EVT_PIN] = pin_irq_next && !pin_change_interrupt_out;
        evt_set[`HCP_EVT_RDY] = cfg_finish;
        evt_set[`HCP_EVT_UPD_DONE] = (upd_reg == UPD_COPY) && pin_batch_copy_done_in;
        evt_set[`HCP_EVT_UPD_REF] = upd_req && (|override_enable_bits_in);
        evt_next = evt_reg;
        if (reg_rd_in && (reg_addr_in == `HCP_OFS_EVT_STS)) begin
            evt_next = '0;
        end
        evt_next = evt_next | evt_set;
    end

    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            evt_reg <= '0;
        end else begin
            evt_reg <= evt_next;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            evt_mask_reg <= `HCP_EVT_MASK_RST;
        end else if (reg_wr_in && (reg_addr_in == `HCP_OFS_EVT_MASK)) begin
            evt_mask_reg <= reg_wdata_in[`HCP_EVT_W-1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!blk_rst_n) begin
            irq_out <= 1'h0;
        end else begin
            irq_out <= |(evt_next & evt_mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // reserved bits zero
    always_comb begin
        rdata_next = 16'h0000;
        if (reg_addr_in == `HCP_OFS_HARDWARE_CONTROL) begin
            rdata_next[`HCP_BIT_GCALL] = general_call_accept_out;
            rdata_next[`HCP_BIT_FMP] = fast_mode_plus_select_out;
            rdata_next[`HCP_BIT_CFGD] = config_done_flag_out;
            rdata_next[`HCP_BIT_UPD] = (upd_reg == UPD_COPY);
        end else if (reg_addr_in == `HCP_OFS_ADDR) begin
            rdata_next[6:0] = bus_target_address_out;
        end else if (reg_addr_in == `HCP_OFS_PIN_LVL) begin
            rdata_next[NPIN-1:0] = pin_sync;
        end else if (reg_addr_in == `HCP_OFS_PIN_CHG) begin
            rdata_next[NPIN-1:0] = pin_change_flags;
        end else if (reg_addr_in == `HCP_OFS_PIN_MASK) begin
            rdata_next[NPIN-1:0] = pin_change_irq_mask_reg;
        end else if (reg_addr_in == `HCP_OFS_TOP_STS) begin
            rdata_next[`HCP_BIT_TOP_PIN] = pin_change_interrupt_out;
            rdata_next[`HCP_BIT_TOP_RDY] = config_done_flag_out;
        end else if (reg_addr_in == `HCP_OFS_EVT_STS) begin
            rdata_next[`HCP_EVT_W-1:0] = evt_reg;
        end else if (reg_addr_in == `HCP_OFS_EVT_MASK) begin
            rdata_next[`HCP_EVT_W-1:0] = evt_mask_reg;
        end
    end

    // read data only stands in the cycle after the read strobe
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_next;
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule : hcp_regs
`default_nettype wire

//--- bench/hcp_regs_monitor.sv
// Purpose: port assertions for the control register block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to hcp_regs from the testbench top file
`timescale 1ns/10ps
`default_nettype none
`include "hcp_map.svh"
module hcp_regs_monitor #(
    parameter int NOVR = 4
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    // side inputs
    input wire logic [6:0] strap_addr_in,
    input wire logic otp_address_override_enable_in,
    input wire logic [6:0] otp_address_value_in,
    input wire logic [NOVR-1:0] override_enable_bits_in,
    input wire logic pin_batch_copy_done_in,
    // outputs
    input wire logic pin_batch_update_request_out,
    input wire logic [6:0] bus_target_address_out,
    input wire logic general_call_accept_out,
    input wire logic fast_mode_plus_select_out,
    input wire logic soft_chip_reset_out,
    input wire logic config_done_flag_out,
    input wire logic pin_change_interrupt_out
);
    logic [7:0] srst_cnt;
    wire ctl_wr = reg_wr_in && reg_addr_in == `HCP_OFS_HARDWARE_CONTROL && !soft_chip_reset_out;
    wire upd_wr = ctl_wr && reg_wdata_in[1] && !reg_wdata_in[0] && !pin_batch_update_request_out;
    // pulse too long to count by repetition
    always_ff @(posedge mclk_in) begin
        srst_cnt <= (rst_n_in && soft_chip_reset_out) ? srst_cnt + 8'h01 : 8'h00;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence srst_wr_s;
        ctl_wr && reg_wdata_in[0];
    endsequence
    sequence srst_run_s;
        soft_chip_reset_out [*8];
    endsequence
    gcall_write_a: assert property (ctl_wr && !reg_wdata_in[0] |=>
        general_call_accept_out == $past(reg_wdata_in[5])) else $error("general call bit wrong");
    fmp_write_a: assert property (ctl_wr && !reg_wdata_in[0] |=>
        fast_mode_plus_select_out == $past(reg_wdata_in[3])) else $error("fast mode bit wrong");
    done_hold_a: assert property (config_done_flag_out |=>
        config_done_flag_out || soft_chip_reset_out) else $error("config done dropped");
    upd_accept_a: assert property (upd_wr && override_enable_bits_in == '0 |=>
        pin_batch_update_request_out) else $error("update not requested");
    upd_finish_a: assert property (pin_batch_update_request_out && pin_batch_copy_done_in
        |=> !pin_batch_update_request_out) else $error("update not cleared");
    upd_refuse_a: assert property (upd_wr && override_enable_bits_in != '0 |=>
        !pin_batch_update_request_out) else $error("update not refused");
    srst_start_a: assert property (srst_wr_s |=> srst_run_s) else $error("soft reset short");
    srst_len_a: assert property ($fell(soft_chip_reset_out) |->
        srst_cnt == 8'(`HCP_SRST_CYC)) else $error("soft reset length wrong");
    srst_config_a: assert property ($fell(soft_chip_reset_out) |->
        !config_done_flag_out ##[38:42] config_done_flag_out) else $error("config late");
    addr_load_a: assert property ($rose(config_done_flag_out) |-> bus_target_address_out ==
        ($past(otp_address_override_enable_in) ? $past(otp_address_value_in) : strap_addr_in))
        else $error("target address not loaded");
    mask_off_a: assert property (reg_wr_in && reg_addr_in == `HCP_OFS_PIN_MASK &&
        reg_wdata_in == 16'h0000 && !soft_chip_reset_out |-> ##2 !pin_change_interrupt_out)
        else $error("masked interrupt high");
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not idle");
endmodule : hcp_regs_monitor
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench for the control register block
// Assumes: reads return data one cycle after the strobe
// Notes:   short run, random strap, pins and otp value
`timescale 1ns/10ps
`default_nettype none
`include "hcp_map.svh"
module testbench;
    logic mclk_in, rst_n_in, wr, rdq, otp_en, cp_done, rd_seen;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, lvl;
    logic [6:0] strap, otp_val, a_out;
    logic [3:0] ovr;
    logic upd, gcall, fmp, srst, done, pin_int, irq;
    logic [31:0] seed = 32'ha867;
    int bad_count = 0;
    int checks = 0;
    logic [15:0] exp_q[$];
    string name_q[$];
    hcp_regs #(.NPIN(16), .NOVR(4)) u_dut (.mclk_in, .rst_n_in,
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rdq),
        .reg_rdata_out(rdata), .pin_level_in(lvl), .strap_addr_in(strap),
        .otp_address_override_enable_in(otp_en), .otp_address_value_in(otp_val),
        .override_enable_bits_in(ovr), .pin_batch_copy_done_in(cp_done),
        .pin_batch_update_request_out(upd), .bus_target_address_out(a_out),
        .general_call_accept_out(gcall), .fast_mode_plus_select_out(fmp),
        .soft_chip_reset_out(srst), .config_done_flag_out(done),
        .pin_change_interrupt_out(pin_int), .irq_out(irq));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] e);
        checks++;
        if (seen !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, seen);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [15:0] e, input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        @(posedge mclk_in);
        addr <= a;
        rdq <= 1'b1;
        @(posedge mclk_in);
        rdq <= 1'b0;
    endtask : rreg
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : cyc
    task automatic wait_done;
        for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge mclk_in);
        #1;
        chk("config_done", 16'(done), 16'h0001);
    endtask : wait_done
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    // read data stands only in the cycle after the strobe
    always @(posedge mclk_in) begin
        if (rd_seen) begin
            chk(name_q.pop_front(), rdata, exp_q.pop_front());
        end
        rd_seen <= rdq;
    end
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (5000) @(posedge mclk_in);
        bad_count++;
        stop_test();
    end
    initial begin
        seed = lfsr(seed);
        strap = seed[6:0];
        seed = lfsr(seed);
        lvl = seed[15:0];
        {rst_n_in, wr, rdq, otp_en, cp_done, addr, wdata, otp_val, ovr} = '0;
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        cyc(1);
        chk("fmp_select", 16'(fmp), 16'h0001);
        chk("gcall_accept", 16'(gcall), 16'h0000);
        rreg(`HCP_OFS_HARDWARE_CONTROL, 16'h0008, "hw_control");
        rreg(`HCP_OFS_PIN_MASK, 16'h0000, "irq_mask");
        rreg(`HCP_OFS_PIN_CHG, 16'h0000, "pin_flags");
        rreg(8'h30, 16'h0000, "unmapped");
        wait_done();
        chk("target_addr", 16'(a_out), 16'(strap));
        chk("irq_masked", 16'(irq), 16'h0000);
        rreg(`HCP_OFS_TOP_STS, 16'h1000, "top_status");
        wreg(`HCP_OFS_HARDWARE_CONTROL, 16'hffe4);
        rreg(`HCP_OFS_HARDWARE_CONTROL, 16'h0024, "hw_control");
        cyc(1);
        chk("gcall_accept", 16'(gcall), 16'h0001);
        chk("fmp_select", 16'(fmp), 16'h0000);
        wreg(`HCP_OFS_ADDR, 16'h00ff);
        rreg(`HCP_OFS_ADDR, 16'h007f, "target_addr");
        wreg(`HCP_OFS_EVT_MASK, 16'h0001);
        @(posedge mclk_in);
        lvl <= lvl ^ 16'h0081;
        cyc(5);
        wreg(`HCP_OFS_PIN_LVL, 16'h0000);
        rreg(`HCP_OFS_PIN_LVL, lvl, "pin_level");
        rreg(`HCP_OFS_PIN_CHG, 16'h0081, "pin_flags");
        chk("pin_int", 16'(pin_int), 16'h0000);
        wreg(`HCP_OFS_PIN_MASK, 16'h0001);
        cyc(2);
        chk("pin_int", 16'(pin_int), 16'h0001);
        chk("irq", 16'(irq), 16'h0001);
        rreg(`HCP_OFS_TOP_STS, 16'h1002, "top_status");
        rreg(`HCP_OFS_EVT_STS, 16'h0003, "events");
        cyc(2);
        chk("irq", 16'(irq), 16'h0000);
        wreg(`HCP_OFS_PIN_CHG, 16'h0100);
        rreg(`HCP_OFS_PIN_CHG, 16'h0081, "pin_flags");
        wreg(`HCP_OFS_PIN_CHG, 16'h0001);
        rreg(`HCP_OFS_PIN_CHG, 16'h0080, "pin_flags");
        cyc(2);
        chk("pin_int", 16'(pin_int), 16'h0000);
        @(posedge mclk_in);
        lvl <= lvl ^ 16'h0001;
        cyc(5);
        rreg(`HCP_OFS_PIN_CHG, 16'h0081, "pin_flags");
        wreg(`HCP_OFS_PIN_MASK, 16'h0000);
        @(posedge mclk_in);
        ovr <= 4'h2;
        wreg(`HCP_OFS_HARDWARE_CONTROL, 16'h0022);
        rreg(`HCP_OFS_HARDWARE_CONTROL, 16'h0024, "hw_control");
        @(posedge mclk_in);
        ovr <= 4'h0;
        wreg(`HCP_OFS_HARDWARE_CONTROL, 16'h0022);
        cyc(1);
        chk("update_req", 16'(upd), 16'h0001);
        rreg(`HCP_OFS_HARDWARE_CONTROL, 16'h0026, "hw_control");
        @(posedge mclk_in);
        cp_done <= 1'b1;
        @(posedge mclk_in);
        cp_done <= 1'b0;
        cyc(1);
        chk("update_req", 16'(upd), 16'h0000);
        rreg(`HCP_OFS_EVT_STS, 16'h000d, "events");
        seed = lfsr(seed);
        @(posedge mclk_in);
        otp_en <= 1'b1;
        otp_val <= seed[6:0];
        wreg(`HCP_OFS_HARDWARE_CONTROL, 16'h0001);
        cyc(1);
        chk("soft_reset", 16'(srst), 16'h0001);
        wait_done();
        chk("target_addr", 16'(a_out), 16'(otp_val));
        rreg(`HCP_OFS_HARDWARE_CONTROL, 16'h000c, "hw_control");
        rreg(`HCP_OFS_PIN_MASK, 16'h0000, "irq_mask");
        cyc(3);
        stop_test();
    end
endmodule : testbench
bind hcp_regs hcp_regs_monitor #(.NOVR(NOVR)) u_mon (.mclk_in, .rst_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .strap_addr_in,
    .otp_address_override_enable_in, .otp_address_value_in, .override_enable_bits_in,
    .pin_batch_copy_done_in, .pin_batch_update_request_out, .bus_target_address_out,
    .general_call_accept_out, .fast_mode_plus_select_out, .soft_chip_reset_out,
    .config_done_flag_out, .pin_change_interrupt_out);
`default_nettype wire
